/* File: rtl/irq_bank_pkg.sv */
package irq_bank_pkg;

    // ========================================================================
    // Register bus geometry and register indices.
    // ========================================================================
    localparam int unsigned AXI_ADDR_W = 12;
    localparam int unsigned AXI_DATA_W = 32;
    localparam logic [7:0]  IDX_CLOCK_CTRL = 8'hE0;
    localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hE2;
    localparam logic [7:0]  IDX_EVENT_FLAG = 8'hE3;
    localparam logic [7:0]  IDX_ROM_BANK   = 8'hF0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ========================================================================
    // Field positions.
    // ========================================================================
    localparam int unsigned BIT_PORT0     = 0;
    localparam int unsigned BIT_TIMER1    = 2;
    localparam int unsigned BIT_TIMER0    = 3;
    localparam int unsigned BIT_DIVIDER   = 4;
    localparam int unsigned BIT_WATCHDOG  = 5;
    localparam int unsigned BIT_LOW_VOLT  = 6;
    localparam int unsigned BIT_DIV_SEL   = 4;
    localparam int unsigned BIT_BANK_PICK = 0;
    localparam logic [7:0]  IRQ_ENABLE_MASK = 8'h1D;
    localparam logic [7:0]  CLEARABLE_MASK  = 8'h3D;

    // ========================================================================
    // Reset values.
    // ========================================================================
    localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] EVENT_FLAG_RST = 8'h00;
    localparam logic       ROM_BANK_RST   = 1'b0;
    localparam logic       DIV_SEL_RST    = 1'b0;
    localparam logic [7:0] PORT0_IDLE     = 8'hFF;

    // ========================================================================
    // Timing counts in oscillator cycles.
    // ========================================================================
    localparam int unsigned DIV_SLOW_CYCLES     = 4096;
    localparam int unsigned DIV_FAST_CYCLES     = 256;
    localparam int unsigned WDT_DEFAULT_CYCLES  = DIV_SLOW_CYCLES * 256;

    // ========================================================================
    // Vectors and CPU memory map.
    // ========================================================================
    localparam logic [15:0] IRQ_VECTOR   = 16'hFFFE;
    localparam logic [15:0] RESET_VECTOR = 16'hFFFC;
    localparam logic [15:0] RAM_BASE     = 16'h0000;
    localparam logic [15:0] RAM_TOP      = 16'h007F;
    localparam logic [15:0] STACK_BASE   = 16'h0100;
    localparam logic [15:0] STACK_TOP    = 16'h017F;
    localparam logic [15:0] SFR_BASE     = 16'h00E0;
    localparam logic [15:0] SFR_TOP      = 16'h00FF;
    localparam logic [15:0] BANK_BASE    = 16'h4000;
    localparam logic [15:0] BANK_TOP     = 16'h7FFF;
    localparam logic [15:0] FIXED_BASE   = 16'h8000;

endpackage

/* File: rtl/tick_if.sv */
`timescale 1ns/1ps

interface tick_if;
    logic div_sel;
    logic wdt_restart;
    logic div_tick;
    logic wdt_overflow;

    modport ctl (
        output div_sel,
        output wdt_restart,
        input  div_tick,
        input  wdt_overflow
    );

    modport timers (
        input  div_sel,
        input  wdt_restart,
        output div_tick,
        output wdt_overflow
    );
endinterface

/* File: rtl/tick_gen.sv */
`timescale 1ns/1ps

module tick_gen
    import irq_bank_pkg::*;
#(
    parameter int unsigned WDT_CYCLES = WDT_DEFAULT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    tick_if.timers    tk
);

    localparam int unsigned WDT_W = $clog2(WDT_CYCLES);

    logic [11:0]      div_cnt_r;
    logic [11:0]      div_mask;
    logic [WDT_W-1:0] wdt_cnt_r;
    logic             wdt_end;

    // ========================================================================
    // Divider: free running, tick at the end of the selected period.
    // ========================================================================
    assign div_mask = tk.div_sel ? 12'(DIV_FAST_CYCLES - 1)
                                 : 12'(DIV_SLOW_CYCLES - 1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_r   <= 12'h000;
            tk.div_tick <= 1'b0;
        end else if (ce) begin
            div_cnt_r   <= div_cnt_r + 12'h001;
            tk.div_tick <= (div_cnt_r & div_mask) == div_mask;
        end
    end

    // ========================================================================
    // Watchdog: restarts on software clear or on its own overflow.
    // ========================================================================
    assign wdt_end = wdt_cnt_r == WDT_W'(WDT_CYCLES - 1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cnt_r       <= '0;
            tk.wdt_overflow <= 1'b0;
        end else if (ce) begin
            tk.wdt_overflow <= wdt_end && !tk.wdt_restart;
            if (tk.wdt_restart || wdt_end) begin
                wdt_cnt_r <= '0;
            end else begin
                wdt_cnt_r <= wdt_cnt_r + WDT_W'(1);
            end
        end
    end

endmodule

/* File: rtl/irq_and_bank_control.sv */
`timescale 1ns/1ps

module irq_and_bank_control
    import irq_bank_pkg::*;
#(
    parameter int unsigned WDT_CYCLES = WDT_DEFAULT_CYCLES
) (
    input  wire  logic                  clk,
    input  wire  logic                  rst_b,
    input  wire  logic                  ce,
    input  wire  logic                  s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire  logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire  logic                  s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire  logic [AXI_DATA_W-1:0] s_axi_wdata,
    input  wire  logic [3:0]            s_axi_wstrb,
    output logic                        s_axi_bvalid,
    input  wire  logic                  s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    input  wire  logic                  s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire  logic [AXI_ADDR_W-1:0] s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire  logic                  s_axi_rready,
    output logic [AXI_DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    input  wire  logic [7:0]            port0_pins,
    input  wire  logic                  timer0_underflow,
    input  wire  logic                  timer1_underflow,
    input  wire  logic                  low_voltage_detect,
    input  wire  logic                  brownout_reset,
    input  wire  logic                  cpu_irq_disable,
    input  wire  logic                  vector_fetch,
    input  wire  logic [15:0]           cpu_addr,
    output logic                        cpu_interrupt_request,
    output logic [15:0]                 vector_addr,
    output logic                        system_reset_request,
    output logic                        ram_select,
    output logic [6:0]                  ram_addr,
    output logic                        sfr_select,
    output logic                        bank_rom_select,
    output logic                        fixed_rom_select,
    output logic [15:0]                 rom_addr
);

    tick_if tk ();

    logic                  aw_held_r;
    logic [AXI_ADDR_W-1:0] aw_addr_r;
    logic                  w_held_r;
    logic [7:0]            w_byte_r;
    logic                  w_lane0_r;
    logic                  do_write;
    logic [8:0]            wr_dec;
    logic                  wr_hit;
    logic [8:0]            rd_dec;
    logic [7:0]            irq_enable_r;
    logic [7:0]            flags_r;
    logic [7:0]            flag_set;
    logic [7:0]            flag_clr;
    logic                  low_voltage_flag_r;
    logic                  div_sel_r;
    logic                  bank_pick_bit_r;
    logic [7:0]            port0_prev_r;
    logic                  reset_pending_r;

    // ========================================================================
    // Register index decode shared by the read and write paths.
    // ========================================================================
    function automatic logic [8:0] decode_index(
        input logic [AXI_ADDR_W-1:0] addr
    );
        logic [7:0] idx;
        logic       hit;
        idx = addr[9:2];
        hit = (addr[1:0] == 2'h0) && (addr[AXI_ADDR_W-1:10] == '0) &&
              (idx == IDX_CLOCK_CTRL || idx == IDX_IRQ_ENABLE ||
               idx == IDX_EVENT_FLAG || idx == IDX_ROM_BANK);
        return {hit, idx};
    endfunction

    function automatic logic in_range(
        input logic [15:0] addr,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        return (addr >= lo) && (addr <= hi);
    endfunction

    // ========================================================================
    // Write channel: address and data taken in either order.
    // ========================================================================
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_dec   = decode_index(aw_addr_r);
    assign wr_hit   = do_write && wr_dec[8] && w_lane0_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_r     <= 1'b0;
            aw_addr_r     <= '0;
            s_axi_awready <= 1'b1;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                aw_held_r     <= 1'b0;
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            w_held_r     <= 1'b0;
            w_byte_r     <= 8'h00;
            w_lane0_r    <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r     <= 1'b1;
                w_byte_r     <= s_axi_wdata[7:0];
                w_lane0_r    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                w_held_r     <= 1'b0;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_dec[8] ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Software-written control registers.
    // ========================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_enable_r <= IRQ_ENABLE_RST;
        end else if (ce && wr_hit && wr_dec[7:0] == IDX_IRQ_ENABLE) begin
            irq_enable_r <= w_byte_r & IRQ_ENABLE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_pick_bit_r <= ROM_BANK_RST;
        end else if (ce && wr_hit && wr_dec[7:0] == IDX_ROM_BANK) begin
            bank_pick_bit_r <= w_byte_r[BIT_BANK_PICK];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_sel_r <= DIV_SEL_RST;
        end else if (ce && wr_hit && wr_dec[7:0] == IDX_CLOCK_CTRL) begin
            div_sel_r <= w_byte_r[BIT_DIV_SEL];
        end
    end

    // ========================================================================
    // Event flags: a set in the same cycle as a clear wins.
    // ========================================================================
    assign tk.div_sel     = div_sel_r;
    assign tk.wdt_restart = flag_clr[BIT_WATCHDOG];

    always_comb begin
        flag_set                = 8'h00;
        flag_set[BIT_PORT0]     = |(port0_prev_r & ~port0_pins);
        flag_set[BIT_TIMER1]    = timer1_underflow;
        flag_set[BIT_TIMER0]    = timer0_underflow;
        flag_set[BIT_DIVIDER]   = tk.div_tick;
        flag_set[BIT_WATCHDOG]  = tk.wdt_overflow;
        flag_clr                = 8'h00;
        if (wr_hit && wr_dec[7:0] == IDX_EVENT_FLAG) begin
            flag_clr = ~w_byte_r & CLEARABLE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port0_prev_r <= PORT0_IDLE;
        end else if (ce) begin
            port0_prev_r <= port0_pins;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= EVENT_FLAG_RST;
        end else if (ce) begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_voltage_flag_r <= 1'b0;
        end else if (ce) begin
            low_voltage_flag_r <= low_voltage_detect;
        end
    end

    // ========================================================================
    // Read channel.
    // ========================================================================
    assign rd_dec = decode_index(s_axi_araddr);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata   <= '0;
                if (rd_dec[8] && rd_dec[7:0] == IDX_EVENT_FLAG) begin
                    s_axi_rdata[7:0]          <= flags_r & CLEARABLE_MASK;
                    s_axi_rdata[BIT_LOW_VOLT] <= low_voltage_flag_r;
                end else if (rd_dec[8] && rd_dec[7:0] == IDX_ROM_BANK) begin
                    s_axi_rdata[BIT_BANK_PICK] <= bank_pick_bit_r;
                end else if (rd_dec[8] && rd_dec[7:0] == IDX_CLOCK_CTRL) begin
                    s_axi_rdata[BIT_DIV_SEL] <= div_sel_r;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Interrupt request and vector selection.
    // ========================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_interrupt_request <= 1'b0;
        end else if (ce) begin
            cpu_interrupt_request <=
                |(irq_enable_r & flags_r & IRQ_ENABLE_MASK)
                && !cpu_irq_disable;
        end
    end

    // A reset cause keeps the reset vector up until the CPU fetches it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_pending_r <= 1'b1;
        end else if (ce) begin
            if (tk.wdt_overflow || brownout_reset) begin
                reset_pending_r <= 1'b1;
            end else if (vector_fetch) begin
                reset_pending_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_addr          <= RESET_VECTOR;
            system_reset_request <= 1'b0;
        end else if (ce) begin
            vector_addr <= (reset_pending_r || tk.wdt_overflow ||
                            brownout_reset) ? RESET_VECTOR
                                            : IRQ_VECTOR;
            system_reset_request <= tk.wdt_overflow;
        end
    end

    // ========================================================================
    // CPU address decode, registered.
    // ========================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ram_select       <= 1'b0;
            ram_addr         <= 7'h00;
            sfr_select       <= 1'b0;
            bank_rom_select  <= 1'b0;
            fixed_rom_select <= 1'b0;
            rom_addr         <= 16'h0000;
        end else if (ce) begin
            ram_select <= in_range(cpu_addr, RAM_BASE, RAM_TOP) ||
                          in_range(cpu_addr, STACK_BASE, STACK_TOP);
            ram_addr   <= cpu_addr[6:0];
            sfr_select <= in_range(cpu_addr, SFR_BASE, SFR_TOP);
            bank_rom_select  <= in_range(cpu_addr, BANK_BASE, BANK_TOP);
            fixed_rom_select <= cpu_addr >= FIXED_BASE;
            if (cpu_addr >= FIXED_BASE) begin
                rom_addr <= cpu_addr;
            end else begin
                rom_addr <= {1'b0, bank_pick_bit_r, cpu_addr[13:0]};
            end
        end
    end

    tick_gen #(
        .WDT_CYCLES (WDT_CYCLES)
    ) u_tick_gen (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .tk    (tk.timers)
    );

endmodule

/* File: bench/irq_bank_props.sv */
`timescale 1ns/1ps
// ========================================
// Bus answer, masking and decode checks.
module irq_bank_props
    import irq_bank_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        ce,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        cpu_irq_disable,
    input wire logic        cpu_interrupt_request,
    input wire logic        system_reset_request,
    input wire logic [15:0] vector_addr,
    input wire logic [15:0] cpu_addr,
    input wire logic        ram_select,
    input wire logic        sfr_select,
    input wire logic        bank_rom_select,
    input wire logic        fixed_rom_select,
    input wire logic [15:0] rom_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b || !ce);
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
    write_release_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    irq_masked_a: assert property (
        cpu_irq_disable |=> !cpu_interrupt_request) else $error("irq not masked");
    reset_vector_a: assert property (
        system_reset_request |=> vector_addr == RESET_VECTOR) else $error("vector");
    ram_decode_a: assert property (
        cpu_addr[15:7] == 9'h000 || cpu_addr[15:7] == 9'h002 |=> ram_select)
        else $error("ram decode");
    sfr_decode_a: assert property (
        cpu_addr[15:5] == 11'h007 |=> sfr_select && !ram_select)
        else $error("sfr decode");
    bank_decode_a: assert property (
        cpu_addr[15:14] == 2'h1 |=> bank_rom_select &&
        (rom_addr & 16'h3FFF) == ($past(cpu_addr) & 16'h3FFF)) else $error("bank");
    fixed_decode_a: assert property (
        cpu_addr[15] |=> fixed_rom_select && rom_addr == $past(cpu_addr))
        else $error("fixed decode");
endmodule

/* File: bench/cpu_model.sv */
`timescale 1ns/1ps
// ========================================
// Core side: fetches the reset vector and counts taken requests.
module cpu_model
    import irq_bank_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        mask_req,
    input  wire logic        cpu_interrupt_request,
    input  wire logic [15:0] vector_addr,
    output logic             cpu_irq_disable,
    output logic             vector_fetch,
    output logic [7:0]       boot_count,
    output logic [7:0]       irq_count
);
    logic armed_r;
    assign cpu_irq_disable = mask_req;
    // One fetch per reset: the vector must leave the reset value to re-arm.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_fetch <= 1'b0;
            armed_r      <= 1'b1;
            boot_count   <= 8'h00;
            irq_count    <= 8'h00;
        end else begin
            vector_fetch <= vector_addr == RESET_VECTOR && armed_r;
            if (vector_addr != RESET_VECTOR)
                armed_r <= 1'b1;
            else if (armed_r)
                armed_r <= 1'b0;
            if (vector_fetch)
                boot_count <= boot_count + 8'h01;
            if (cpu_interrupt_request && !cpu_irq_disable &&
                vector_addr == IRQ_VECTOR)
                irq_count <= irq_count + 8'h01;
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
// ========================================
// Register-level tests of the interrupt and bank block.
module tb_top
    import irq_bank_pkg::*;
;
    localparam int unsigned WDT = 300;
    logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, mask_req = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, vector_fetch, cpu_irq_disable;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [7:0]  port0_pins = 8'hFF, boot_count, irq_count, m, k;
    logic        timer0_underflow = 1'b0, timer1_underflow = 1'b0;
    logic        low_voltage_detect = 1'b0, brownout_reset = 1'b0;
    logic        cpu_interrupt_request, system_reset_request, ram_select;
    logic        sfr_select, bank_rom_select, fixed_rom_select;
    logic [15:0] cpu_addr = 16'h0000, vector_addr, rom_addr;
    logic [6:0]  ram_addr;
    logic [15:0] al [4] = '{16'h0042, 16'h00E5, 16'h4000, 16'hFFFF};
    int          src [3] = '{0, 2, 3};
    int          bad_count = 0, samples_checked = 0;
    int          rst_seen = 0, seen0 = 0;
    irq_and_bank_control #(.WDT_CYCLES(WDT)) dut_u (.*);
    cpu_model cpu_u (.*);
    always #5 clk = ~clk;
    always @(posedge clk) if (system_reset_request === 1'b1) rst_seen <= rst_seen + 1;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic ev(input int s);
        @(posedge clk);
        if (s == 0) port0_pins <= 8'h7F;
        timer1_underflow <= s == 2;
        timer0_underflow <= s == 3;
        @(posedge clk);
        port0_pins       <= 8'hFF;
        timer1_underflow <= 1'b0;
        timer0_underflow <= 1'b0;
    endtask
    task automatic conclude;
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #150us;
        bad_count++;
        $display("Error watchdog expired");
        conclude();
    end
    initial begin
        cyc(10);
        rst_b <= 1'b1;
        rd(12'h388); chk("irq_enable_mask", d, 32'h0);
        rd(12'h3C0); chk("rom_bank_select", d, 32'h0);
        rd(12'h384); chk("unmapped_resp", r, RESP_SLVERR);
        wr(12'h384, 8'h01); chk("unmapped_bresp", r, RESP_SLVERR);
        wr(12'h3C0, 8'h01);
        chk("bank_bresp", r, RESP_OKAY);
        rd(12'h3C0);
        chk("rom_bank_select", d, 32'h1);
        cpu_addr <= 16'h6123; cyc(2); chk("rom_addr", rom_addr, 16'h6123);
        wr(12'h3C0, 8'h00); cyc(2); chk("rom_addr", rom_addr, 16'h2123);
        s_axi_wstrb <= 4'hE;
        wr(12'h3C0, 8'h01);
        s_axi_wstrb <= 4'hF;
        rd(12'h3C0);
        chk("lane_off_write", d, 32'h0);
        cpu_addr <= 16'h0150; cyc(2); chk("ram_addr", ram_addr, 7'h50);
        for (int i = 0; i < 4; i++) begin
            cpu_addr <= al[i];
            cyc(2);
        end
        $display("Test decode done");
        for (int i = 0; i < 3; i++) begin
            m = 8'h01 << src[i];
            wr(12'h388, 8'h00); wr(12'h38C, 8'h00);
            ev(src[i]); cyc(3);
            chk("irq_request", cpu_interrupt_request, 0);
            rd(12'h38C); chk("flags", d & 32'hFFFFFFDF, m);
            k = irq_count;
            wr(12'h388, m); cyc(3);
            chk("irq_request", cpu_interrupt_request, 1);
            chk("irq_taken", irq_count != k, 1);
            wr(12'h38C, 8'hFF); rd(12'h38C);
            chk("flags", d & 32'hFFFFFFDF, m);
            mask_req <= 1'b1; cyc(3);
            chk("irq_request", cpu_interrupt_request, 0);
            mask_req <= 1'b0;
            wr(12'h38C, ~m); cyc(3); rd(12'h38C);
            chk("flags", d & 32'hFFFFFFDF, 0);
            chk("irq_request", cpu_interrupt_request, 0);
        end
        $display("Test sources done");
        low_voltage_detect <= 1'b1; cyc(2); wr(12'h38C, 8'h00); rd(12'h38C);
        chk("low_voltage", d & 32'h40, 32'h40);
        low_voltage_detect <= 1'b0; cyc(2); rd(12'h38C);
        chk("low_voltage", d & 32'h40, 0);
        wr(12'h38C, 8'hDF); rd(12'h38C); chk("wdt_flag", d & 32'h20, 0);
        cyc(WDT - 40); rd(12'h38C); chk("wdt_flag", d & 32'h20, 0);
        k = boot_count;
        seen0 = rst_seen;
        cyc(60); rd(12'h38C); chk("wdt_flag", d & 32'h20, 32'h20);
        chk("reset_request", rst_seen - seen0, 1);
        chk("boot_count", boot_count, k + 8'h01);
        k = boot_count;
        brownout_reset <= 1'b1; cyc(1); brownout_reset <= 1'b0; cyc(6);
        chk("boot_count", boot_count, k + 8'h01);
        $display("Test watchdog done");
        wr(12'h380, 8'h10); rd(12'h380); chk("rate_select", d, 32'h10);
        wr(12'h38C, 8'hEF); cyc(270); rd(12'h38C);
        chk("div_flag", d & 32'h10, 32'h10);
        wr(12'h388, 8'h10); cyc(3);
        chk("irq_request", cpu_interrupt_request, 1);
        wr(12'h388, 8'h00); wr(12'h380, 8'h00); wr(12'h38C, 8'hEF);
        cyc(4100); rd(12'h38C); chk("div_flag", d & 32'h10, 32'h10);
        $display("Test divider done");
        conclude();
    end
endmodule
bind irq_and_bank_control irq_bank_props props_u (.*);
